/* File: include/prs_pkg.sv */
// constants and types of the power-on reset sequencer
// Summary of operation
// - power-on phase lasts sixteen system clocks
// - power-on indication waits for all init feedback
// - two more system clocks, then bus clock
// - reset exit phase of seventy bus clocks
// - low voltage holds reset until rise threshold
// - low voltage end replays the power-on sequence
// - any reset sets both drop enable bits
// - pin low during power-on selects external flow
// - pin low during low voltage selects external flow
// - three causes raise bad opcode reset
// - bad address and debug command reset synchronously
// - pin and watchdog resynchronized to system clock
// - reset pin is input only
// - sync sources cleared; exit after 71 bus clocks
package prs_pkg;
    // sequence counts
    localparam logic [6:0] POR_SYS_CYC       = 7'h10;
    localparam logic [6:0] GAP_SYS_CYC       = 7'h02;
    localparam logic [6:0] EXIT_BUS_CYC      = 7'h46;
    localparam logic [6:0] SYNC_EXIT_BUS_CYC = 7'h47;

    // asynchronous inputs passing the synchroniser
    localparam int SRC_N    = 4;
    localparam int SRC_EXT  = 0;
    localparam int SRC_WDOG = 1;
    localparam int SRC_DROP = 2;
    localparam int SRC_RISE = 3;
    localparam int INIT_N   = 4;

    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CLEAR  = 8'h04;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_CTRL   = 8'h0C;
    localparam logic [7:0] ADDR_STATE  = 8'h10;

    // status and enable bit positions
    localparam int ST_POR   = 0;
    localparam int ST_LOWV  = 1;
    localparam int ST_EXT   = 2;
    localparam int ST_WDOG  = 3;
    localparam int ST_BADOP = 4;
    localparam int ST_BADAD = 5;
    localparam int ST_DBG   = 6;
    localparam int ST_DONE  = 7;

    // control bit positions
    localparam int CTRL_DETECT = 0;
    localparam int CTRL_RESET  = 1;

    // values after reset
    localparam logic [7:0] STATUS_RST = 8'h01;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [1:0] CTRL_RST   = 2'h3;

    typedef enum logic [2:0] {
        S_PWRON,
        S_GAP,
        S_EXIT,
        S_LVHOLD,
        S_EXTHOLD,
        S_RUN
    } prs_state_t;
endpackage

/* File: include/prs_src_if.sv */
// carrier of raw and synchronised asynchronous reset inputs
`timescale 1ns/1ps
interface prs_src_if;
    logic [prs_pkg::SRC_N-1:0] raw;
    logic [prs_pkg::SRC_N-1:0] synced;

    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

/* File: design/prs_sync.sv */
// two-stage synchroniser for the asynchronous reset inputs
`timescale 1ns/1ps
module prs_sync (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  sys_rst,
    // raw and synchronised levels
    prs_src_if.sync_side src
);
    logic [prs_pkg::SRC_N-1:0] stage1;
    logic [prs_pkg::SRC_N-1:0] stage2;

    genvar i;
    generate
        for (i = 0; i < prs_pkg::SRC_N; i++) begin : g_bit
            // stage1 feeds only stage2
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= src.raw[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    assign src.synced = stage2;
endmodule // prs_sync

/* File: design/prs_sequencer.sv */
// power-on reset sequencer with apb register file
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module prs_sequencer (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // asynchronous reset sources
    input  wire logic                        rstPinN,
    input  wire logic                        watchdogTimeout,
    input  wire logic                        supplyDrop,
    input  wire logic                        supplyRiseOk,
    // synchronous reset sources
    input  wire logic                        illegalInstr,
    input  wire logic                        backgroundInstruction,
    input  wire logic                        debugEnable,
    input  wire logic                        stopInstr,
    input  wire logic                        stopEnable,
    input  wire logic                        badAddress,
    input  wire logic                        debugResetCmd,
    // power-on handshake
    input  wire logic [prs_pkg::INIT_N-1:0]  initDone,
    output logic                             porInd,
    // clocking and reset outputs
    output logic                             busClkEn,
    output logic                             busClk,
    output logic                             sysReset,
    output logic                             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    prs_src_if src ();

    // the pin is only ever read here, never driven
    assign src.raw = {supplyRiseOk, supplyDrop, watchdogTimeout, ~rstPinN};

    prs_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .src     (src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // sequencer state
    prs_pkg::prs_state_t state;
    prs_pkg::prs_state_t next_state;

    // phase counting
    logic [7:0]          seqCnt;
    logic [7:0]          exitLim;
    logic [7:0]          next_exitLim;
    logic                seqDone;
    logic [7:0]          porLast;
    logic [7:0]          gapLast;
    logic [7:0]          asyncExitLim;
    logic [7:0]          syncExitLim;

    // synchronised asynchronous sources
    logic                extSync;
    logic                wdogSync;
    logic                dropSync;
    logic                riseSync;

    // synchronous sources
    logic                runNow;
    logic                badOpcode;
    logic                syncHit;
    logic                dropArmed;

    // register file
    logic [7:0]          status;
    logic [7:0]          enable;
    logic [1:0]          ctrl;
    logic [7:0]          evt;
    logic [7:0]          clrMask;

    // bus decode
    logic                apbAccess;
    logic                apbWrite;
    logic                apbSetupRead;
    logic                addrOk;
    logic [31:0]         readMux;

    ////////////////////////////////////////////////////////////////////////////
    // phase lengths

    // counters run on the system clock, so bus counts are doubled
    assign porLast      = {1'b0, prs_pkg::POR_SYS_CYC} - 8'h01;
    assign gapLast      = {1'b0, prs_pkg::GAP_SYS_CYC} - 8'h01;
    assign asyncExitLim = {prs_pkg::EXIT_BUS_CYC, 1'b0};
    assign syncExitLim  = {prs_pkg::SYNC_EXIT_BUS_CYC, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // source decode

    assign extSync  = src.synced[prs_pkg::SRC_EXT];
    assign wdogSync = src.synced[prs_pkg::SRC_WDOG];
    assign dropSync = src.synced[prs_pkg::SRC_DROP];
    assign riseSync = src.synced[prs_pkg::SRC_RISE];

    assign runNow = (state == prs_pkg::S_RUN);

    // the three ways of running an instruction that is not allowed
    assign badOpcode = illegalInstr
                     | (backgroundInstruction & ~debugEnable)
                     | (stopInstr & ~stopEnable);

    // only honoured while running: a source still high once reset
    // is asserted is dropped, so it cannot restart the exit count
    assign syncHit = runNow
                   & (badOpcode | badAddress | debugResetCmd);

    // a drop only resets when both control bits allow it
    assign dropArmed = dropSync
                     & ctrl[prs_pkg::CTRL_DETECT]
                     & ctrl[prs_pkg::CTRL_RESET];

    ////////////////////////////////////////////////////////////////////////////
    // phase end detection

    always_comb begin
        seqDone = 1'b0;
        case (state)
            prs_pkg::S_PWRON: begin
                // sixteen clocks and every init circuit answering
                seqDone = (seqCnt >= porLast) && (&initDone);
            end
            prs_pkg::S_GAP: begin
                seqDone = (seqCnt == gapLast);
            end
            prs_pkg::S_EXIT: begin
                seqDone = (seqCnt == (exitLim - 8'h01));
            end
            default: begin
                seqDone = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_state   = state;
        next_exitLim = exitLim;
        if (extSync) begin
            // the pin takes over from any flow in progress
            next_state = prs_pkg::S_EXTHOLD;
        end else if (dropArmed && (state != prs_pkg::S_LVHOLD)) begin
            next_state = prs_pkg::S_LVHOLD;
        end else begin
            case (state)
                prs_pkg::S_PWRON: begin
                    if (seqDone) begin
                        next_state   = prs_pkg::S_GAP;
                        next_exitLim = asyncExitLim;
                    end
                end
                prs_pkg::S_GAP: begin
                    if (seqDone) begin
                        next_state = prs_pkg::S_EXIT;
                    end
                end
                prs_pkg::S_EXIT: begin
                    if (seqDone) begin
                        next_state = prs_pkg::S_RUN;
                    end
                end
                prs_pkg::S_LVHOLD: begin
                    // hold until the rising comparator clears the drop
                    if (!dropSync && riseSync) begin
                        next_state = prs_pkg::S_PWRON;
                    end
                end
                prs_pkg::S_EXTHOLD: begin
                    // pin released: retimed flow, same exit count
                    next_state   = prs_pkg::S_GAP;
                    next_exitLim = asyncExitLim;
                end
                prs_pkg::S_RUN: begin
                    if (wdogSync) begin
                        next_state   = prs_pkg::S_GAP;
                        next_exitLim = asyncExitLim;
                    end else if (syncHit) begin
                        // no retiming needed, straight to the exit count
                        next_state   = prs_pkg::S_EXIT;
                        next_exitLim = syncExitLim;
                    end
                end
                default: begin
                    next_state = prs_pkg::S_PWRON;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state and counters

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= prs_pkg::S_PWRON;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            exitLim <= {prs_pkg::EXIT_BUS_CYC, 1'b0};
        end else begin
            exitLim <= next_exitLim;
        end
    end

    // restarts on every phase change; saturates while waiting for init
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seqCnt <= 8'h00;
        end else if (next_state != state) begin
            seqCnt <= 8'h00;
        end else if (seqCnt != 8'hFF) begin
            seqCnt <= seqCnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset and clock outputs

    // reset is low only in the run state, so every source reaches it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysReset <= 1'b1;
        end else begin
            sysReset <= (next_state != prs_pkg::S_RUN);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busClkEn <= 1'b0;
        end else begin
            busClkEn <= (next_state == prs_pkg::S_EXIT)
                     || (next_state == prs_pkg::S_RUN);
        end
    end

    // halves the system clock; parked low while disabled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busClk <= 1'b0;
        end else if (busClkEn) begin
            busClk <= ~busClk;
        end else begin
            busClk <= 1'b0;
        end
    end

    // an external reset may leave the power-on phase early; the
    // indication then stays up until init feedback is complete
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            porInd <= 1'b1;
        end else if ((next_state == prs_pkg::S_PWRON) && (state != prs_pkg::S_PWRON)) begin
            porInd <= 1'b1;
        end else if ((&initDone) && ((state != prs_pkg::S_PWRON) || seqDone)) begin
            porInd <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits

    // forced back to both-enabled while reset is asserted
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= prs_pkg::CTRL_RST;
        end else if (sysReset) begin
            ctrl <= prs_pkg::CTRL_RST;
        end else if (apbWrite && (paddr == prs_pkg::ADDR_CTRL)) begin
            ctrl <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable <= prs_pkg::ENABLE_RST;
        end else if (apbWrite && (paddr == prs_pkg::ADDR_ENABLE)) begin
            enable <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status events

    always_comb begin
        evt                    = 8'h00;
        evt[prs_pkg::ST_POR]   = (next_state == prs_pkg::S_PWRON)
                               && (state != prs_pkg::S_PWRON);
        evt[prs_pkg::ST_LOWV]  = dropSync & ctrl[prs_pkg::CTRL_DETECT];
        evt[prs_pkg::ST_EXT]   = extSync;
        evt[prs_pkg::ST_WDOG]  = wdogSync & runNow;
        evt[prs_pkg::ST_BADOP] = badOpcode & runNow;
        evt[prs_pkg::ST_BADAD] = badAddress & runNow;
        evt[prs_pkg::ST_DBG]   = debugResetCmd & runNow;
        evt[prs_pkg::ST_DONE]  = (state == prs_pkg::S_EXIT)
                               && (next_state == prs_pkg::S_RUN);
    end

    assign clrMask = (apbWrite && (paddr == prs_pkg::ADDR_CLEAR)) ? pwdata[7:0] : 8'h00;

    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_status
            // set beats clear so an event in the clearing cycle is kept
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    status[b] <= prs_pkg::STATUS_RST[b];
                end else if (evt[b]) begin
                    status[b] <= 1'b1;
                end else if (clrMask[b]) begin
                    status[b] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(status & enable);

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    // no wait states: read data is loaded in the setup cycle
    assign apbAccess    = psel & penable;
    assign pready       = apbAccess;
    assign apbWrite     = apbAccess & pwrite;
    assign apbSetupRead = psel & ~penable & ~pwrite;
    assign pslverr      = apbAccess & ~addrOk;

    always_comb begin
        addrOk  = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            prs_pkg::ADDR_STATUS: begin
                readMux = {24'h00_0000, status};
            end
            prs_pkg::ADDR_CLEAR: begin
                // write-only, reads as zero
                readMux = 32'h0000_0000;
            end
            prs_pkg::ADDR_ENABLE: begin
                readMux = {24'h00_0000, enable};
            end
            prs_pkg::ADDR_CTRL: begin
                readMux = {30'h0000_0000, ctrl};
            end
            prs_pkg::ADDR_STATE: begin
                readMux = {29'h0000_0000, state};
            end
            default: begin
                addrOk  = 1'b0;
                readMux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetupRead) begin
            prdata <= readMux;
        end
    end
endmodule // prs_sequencer

/* File: test/prs_supply_model.sv */
// supply comparators and reset pin model
`timescale 1ns/1ps
module prs_supply_model (
    input  wire logic clk, dropReq, pinReq,
    output logic      supplyDrop, supplyRiseOk, rstPinN
);
    assign supplyDrop = dropReq;
    // rise lags fall by a clock, standing in for hysteresis
    always_ff @(posedge clk) supplyRiseOk <= !dropReq;
    assign rstPinN = !pinReq;
endmodule // prs_supply_model

/* File: test/prs_sequencer_chk.sv */
// port assertions of the reset sequencer
`timescale 1ns/1ps
module prs_sequencer_chk (
    input wire logic clk, sys_rst, supplyDrop, illegalInstr, badAddress, debugResetCmd,
    input wire logic porInd, busClkEn, busClk, sysReset,
    input wire logic [prs_pkg::INIT_N-1:0] initDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_BUSDIV: assert property ($past(busClkEn) && busClkEn |-> busClk != $past(busClk))
        else $error("bus clock");
    AST_LVHOLD: assert property (supplyDrop [*6] |-> sysReset)
        else $error("low voltage");
    AST_EXITHOLD: assert property ($rose(busClkEn) |-> sysReset [*8])
        else $error("exit hold");
    AST_EXITLEN: assert property ($fell(sysReset) |-> $past(busClkEn, 100))
        else $error("exit early");
    AST_BADAD: assert property (badAddress && !sysReset |-> ##[1:4] sysReset)
        else $error("bad address");
    AST_DBGCMD: assert property (debugResetCmd && !sysReset |-> ##[1:4] sysReset)
        else $error("debug reset");
    AST_BADOP: assert property (illegalInstr && !sysReset |-> ##[1:4] sysReset)
        else $error("bad opcode");
    AST_PORIND: assert property (porInd && !(&initDone) |=> porInd)
        else $error("power-on flag");
endmodule // prs_sequencer_chk
bind prs_sequencer prs_sequencer_chk i_chk (.*);

/* File: test/power_on_reset_sequencer_tb_top.sv */
// bench of the reset sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module power_on_reset_sequencer_tb_top;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, watchdogTimeout = 0;
    logic dropReq = 0, pinReq = 0, pready, pslverr, porInd, busClkEn, busClk, sysReset, irq;
    logic supplyDrop, supplyRiseOk, rstPinN, illegalInstr, backgroundInstruction, debugEnable;
    logic stopInstr, stopEnable, badAddress, debugResetCmd;
    logic [6:0] src = 7'h14, tbl [5] = '{7'h15, 7'h12, 7'h0C, 7'h34, 7'h54};
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] initDone = '0;
    int n_mismatch = 0, cmp_count = 0, seed = 47299, n, h;
    int porLen = prs_pkg::POR_SYS_CYC + prs_pkg::GAP_SYS_CYC + 2 * prs_pkg::EXIT_BUS_CYC;
    assign {debugResetCmd, badAddress, stopEnable, stopInstr, debugEnable,
        backgroundInstruction, illegalInstr} = src;
    always #25 clk = ~clk;
    prs_supply_model i_sup (.*);
    prs_sequencer i_dut (.*);
    task automatic results(input int bad = 0);
        n_mismatch += bad;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk) penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1 && ++i < 99);
        rd = prdata;
        {psel, penable} <= 2'h0;
        if (i > 98) results(1);
    endtask
    // counts cycles until system reset is released
    task automatic span(output int c);
        c = 0;
        while (sysReset !== 1'h0 && ++c < 3000) @(posedge clk);
        if (c > 2998) results(1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (6) @(posedge clk);
        initDone <= 4'hF;
        span(n);
        `CHK(n + 6 >= porLen, 1'h1)
        apb(1'h0, prs_pkg::ADDR_CTRL, '0);
        `CHK(rd[1:0], prs_pkg::CTRL_RST)
        apb(1'h1, prs_pkg::ADDR_ENABLE, 32'hFF);
        @(negedge clk);
        `CHK(irq, 1'h1)
        apb(1'h1, prs_pkg::ADDR_CLEAR, 32'hFF);
        apb(1'h0, 8'h3C, '0);
        @(negedge clk);
        `CHK(irq, 1'h0)
        for (int k = 0; k < 8; k++) begin
            h = 8 + {$random(seed)} % 4;
            src <= k < 5 ? tbl[k] : 7'h14;
            {watchdogTimeout, pinReq, dropReq} <= {k == 5, k == 6, k == 7};
            repeat (h) @(posedge clk);
            src <= 7'h14;
            {watchdogTimeout, pinReq, dropReq} <= 3'h0;
            span(n);
            `CHK(n + h >= (k < 5 ? 2 * prs_pkg::SYNC_EXIT_BUS_CYC : 2 * prs_pkg::EXIT_BUS_CYC), 1'h1)
            $display("source %0d done", k);
        end
        results();
    end
endmodule // power_on_reset_sequencer_tb_top
